// ==== logic/pwmcc_pkg.sv ====
// Constants, types and register map of the six-channel PWM control block.
// What this block does
// - Output-enable bit 5 runs channel five and drives it onto pin P2.5.
// - Output-enable bit 4 runs channel four and drives it onto pin P2.4.
// - Output-enable bit 3 runs channel three and drives it onto pin P2.3.
// - Output-enable bit 2 runs channel two and drives it onto pin P1.6.
// - Output-enable bit 1 runs channel one and drives it onto pin P1.3.
// - Output-enable bit 0 runs channel zero and drives it onto pin P1.2.
// - Clear-control bit 7 enables channel two interrupt, also gated by group.
// - Clear-control bit 5 holds channel five cleared and stopped.
// - Clear-control bit 4 holds channel four cleared and stopped.
// - Clear-control bit 3 holds channel three cleared and stopped.
// - Clear-control bit 2 holds channel two cleared and stopped.
// - Clear-control bit 1 holds channel one cleared and stopped.
// - Clear-control bit 0 holds channel zero cleared and stopped.
// - Clock-control bit 6 picks system or RC clock for channels 3 to 5.
// - Two-bit selects pick system, RC or twice RC clock for channels 0 to 2.
// - One group enable gates every interrupt of channels zero to two.
// - Upper group clock passes a prescaler dividing by two to the code.
package pwmcc_pkg;
  localparam int          NCH       = 6;
  localparam int          NLOW      = 3;
  localparam int          ADDR_W    = 12;
  localparam int          DATA_W    = 32;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0]  IDX_PRD   = 8'h9a;
  localparam logic [7:0]  IDX_DUTY3 = 8'h9b;
  localparam logic [7:0]  IDX_DUTY4 = 8'h9c;
  localparam logic [7:0]  IDX_DUTY5 = 8'h9d;
  localparam logic [7:0]  IDX_OE    = 8'h9e;
  localparam logic [7:0]  IDX_CLR   = 8'h9f;
  localparam logic [7:0]  IDX_CKS   = 8'ha1;
  localparam logic [7:0]  IDX_DUTY0 = 8'hb0;
  localparam logic [7:0]  IDX_DUTY1 = 8'hb1;
  localparam logic [7:0]  IDX_DUTY2 = 8'hb2;
  localparam logic [7:0]  IDX_IRQC  = 8'hb3;
  localparam logic [7:0]  IDX_IRQS  = 8'hb4;
  localparam logic [7:0]  IDX_PSC   = 8'hb5;
  // Field positions.
  localparam int          CH2_IE_BIT = 7;
  localparam int          GRP_IE_BIT = 7;
  localparam int          UP_CKS_BIT = 6;
  // Reset values, lower group counter top and register write masks.
  localparam logic [7:0]  RST_OE    = 8'h00;
  localparam logic [7:0]  RST_CLR   = 8'h00;
  localparam logic [7:0]  RST_CKS   = 8'h6a;
  localparam logic [7:0]  RST_PRD   = 8'hff;
  localparam logic [7:0]  RST_DUTY  = 8'h00;
  localparam logic [7:0]  LOW_TOP   = 8'hff;
  localparam logic [7:0]  OE_MASK   = 8'h3f;
  localparam logic [7:0]  CLR_MASK  = 8'hbf;
  localparam logic [7:0]  CKS_MASK  = 8'h7f;
  localparam logic [7:0]  IRQC_MASK = 8'h83;
  // Clock select codes and bus response codes.
  localparam logic [1:0]  CKS_RC    = 2'h2;
  localparam logic [1:0]  CKS_RC2   = 2'h3;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;

  typedef enum logic [12:0] {
    REG_NONE  = 13'h0001,
    REG_PRD   = 13'h0002,
    REG_DUTY  = 13'h0004,
    REG_OE    = 13'h0008,
    REG_CLR   = 13'h0010,
    REG_CKS   = 13'h0020,
    REG_IRQC  = 13'h0040,
    REG_IRQS  = 13'h0080,
    REG_PSC   = 13'h0100
  } pwmcc_reg_e;

  typedef struct packed {
    logic                    aw_have;
    logic [ADDR_W-1:0]       aw_addr;
    logic                    w_have;
    logic [7:0]              w_data;
    logic                    w_lane0;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [1:0]              rresp;
    logic [7:0]              rdata;
    logic [7:0]              oe;
    logic [7:0]              clr;
    logic [7:0]              cks;
    logic [7:0]              prd;
    logic [NCH-1:0][7:0]     duty;
    logic [7:0]              irqc;
    logic [NLOW-1:0]         irqs;
    logic [2:0]              psc;
    logic [6:0]              psc_cnt;
    logic [NCH-1:0][7:0]     cnt;
    logic [NCH-1:0]          pin;
    logic [NCH-1:0]          pin_oe;
    logic                    irq;
  } pwmcc_state_s;
endpackage

// ==== logic/pwmcc_top.sv ====
// Six-channel PWM control block with AXI4-Lite registers and interrupt.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module pwmcc_top import pwmcc_pkg::*; (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Internal RC clock as one-cycle ticks in the clk domain
  input  wire logic              rc_tick,
  input  wire logic              rc2_tick,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Pins P1.2, P1.3, P1.6, P2.3, P2.4, P2.5 as channels 0 to 5
  output logic [NCH-1:0]         pwm_pin,
  output logic [NCH-1:0]         pwm_pin_oe,
  // Interrupt
  output logic                   irq
);

  pwmcc_state_s s_q;
  pwmcc_state_s s_d;
  logic [NCH-1:0] tick;
  logic           up_src;
  logic           up_tick;
  logic [6:0]     psc_mask;

  function automatic pwmcc_reg_e reg_decode(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    if (a[1:0] != 2'h0 || a[ADDR_W-1:10] != '0) begin
      return REG_NONE;
    end
    case (idx)
      IDX_PRD:   return REG_PRD;
      IDX_DUTY0, IDX_DUTY1, IDX_DUTY2,
      IDX_DUTY3, IDX_DUTY4, IDX_DUTY5: return REG_DUTY;
      IDX_OE:    return REG_OE;
      IDX_CLR:   return REG_CLR;
      IDX_CKS:   return REG_CKS;
      IDX_IRQC:  return REG_IRQC;
      IDX_IRQS:  return REG_IRQS;
      IDX_PSC:   return REG_PSC;
      default:   return REG_NONE;
    endcase
  endfunction

  function automatic int duty_index(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    if (idx >= IDX_DUTY0) begin
      return int'(idx - IDX_DUTY0);
    end
    return int'(idx - IDX_DUTY3) + NLOW;
  endfunction

  function automatic logic src_tick(input logic [1:0] sel,
                                    input logic rc, input logic rc2);
    case (sel)
      CKS_RC:  return rc;
      CKS_RC2: return rc2;
      default: return 1'b1;
    endcase
  endfunction

  // The RC clock is only an enable here, so a select change can never
  // make a short pulse on another channel's clock.
  assign up_src   = s_q.cks[UP_CKS_BIT] ? rc_tick : 1'b1;
  assign psc_mask = 7'((8'h01 << s_q.psc) - 8'h01);
  assign up_tick  = up_src && ((s_q.psc_cnt & psc_mask) == psc_mask);

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_tick
      if (gi < NLOW) begin : g_low
        assign tick[gi] = src_tick(s_q.cks[2*gi+1 -: 2], rc_tick,
                                   rc2_tick);
      end else begin : g_up
        assign tick[gi] = up_tick;
      end
    end
  endgenerate

  always_comb begin
    pwmcc_reg_e   wsel;
    pwmcc_reg_e   rsel;
    logic [7:0]   wv;
    logic [7:0]   top;
    logic         run;
    logic [NLOW-1:0] ev;
    logic [NLOW-1:0] ien;
    s_d  = s_q;
    wsel = REG_NONE;
    rsel = REG_NONE;
    wv   = s_q.w_data;
    top  = LOW_TOP;
    run  = 1'b0;
    ev   = '0;
    ien  = '0;

    // Write address and data are taken in either order.
    if (s_q.awready && s_axi_awvalid) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_q.wready && s_axi_wvalid) begin
      s_d.w_have  = 1'b1;
      s_d.w_data  = s_axi_wdata[7:0];
      s_d.w_lane0 = s_axi_wstrb[0];
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // Upper group prescaler advances on every source tick.
    if (up_src) begin
      s_d.psc_cnt = s_q.psc_cnt + 7'h01;
    end

    // Channel counters and pins.
    for (int i = 0; i < NCH; i++) begin
      top = (i >= NLOW) ? s_q.prd : LOW_TOP;
      run = s_q.oe[i] && !s_q.clr[i];
      if (!run) begin
        s_d.cnt[i] = '0;
      end else if (tick[i]) begin
        if (s_q.cnt[i] == top) begin
          s_d.cnt[i] = '0;
          if (i < NLOW) begin
            ev[i] = 1'b1;
          end
        end else begin
          s_d.cnt[i] = s_q.cnt[i] + 8'h01;
        end
      end
      s_d.pin[i]    = run && (s_q.cnt[i] < s_q.duty[i]);
      s_d.pin_oe[i] = s_q.oe[i];
    end

    // Register write when both halves are held.
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      wsel        = reg_decode(s_q.aw_addr);
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = (wsel == REG_NONE) ? RESP_ERR : RESP_OK;
      if (s_q.w_lane0) begin
        case (wsel)
          REG_PRD:  s_d.prd = wv;
          REG_DUTY: s_d.duty[duty_index(s_q.aw_addr)] = wv;
          REG_OE:   s_d.oe = wv & OE_MASK;
          REG_CLR:  s_d.clr = wv & CLR_MASK;
          REG_CKS:  s_d.cks = wv & CKS_MASK;
          REG_IRQC: s_d.irqc = wv & IRQC_MASK;
          REG_IRQS: s_d.irqs = s_q.irqs & ~wv[NLOW-1:0];
          REG_PSC:  s_d.psc = wv[2:0];
          default:  s_d.bresp = RESP_ERR;
        endcase
      end
    end

    // A period end in the same cycle as a clearing write stays set.
    s_d.irqs = s_d.irqs | ev;
    ien = {s_q.clr[CH2_IE_BIT], s_q.irqc[1:0]};
    s_d.irq = s_q.irqc[GRP_IE_BIT] && |(s_q.irqs & ien);

    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready  = !s_d.w_have && !s_d.bvalid;

    // Read channel.
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_q.arready && s_axi_arvalid) begin
      rsel       = reg_decode(s_axi_araddr);
      s_d.rvalid = 1'b1;
      s_d.rresp  = (rsel == REG_NONE) ? RESP_ERR : RESP_OK;
      case (rsel)
        REG_PRD:  s_d.rdata = s_q.prd;
        REG_DUTY: s_d.rdata = s_q.duty[duty_index(s_axi_araddr)];
        REG_OE:   s_d.rdata = s_q.oe;
        REG_CLR:  s_d.rdata = s_q.clr;
        REG_CKS:  s_d.rdata = s_q.cks;
        REG_IRQC: s_d.rdata = s_q.irqc;
        REG_IRQS: s_d.rdata = {5'h00, s_q.irqs};
        REG_PSC:  s_d.rdata = {5'h00, s_q.psc};
        default:  s_d.rdata = 8'h00;
      endcase
    end
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q         <= '0;
      s_q.oe      <= RST_OE;
      s_q.clr     <= RST_CLR;
      s_q.cks     <= RST_CKS;
      s_q.prd     <= RST_PRD;
      s_q.duty    <= {NCH{RST_DUTY}};
      s_q.awready <= 1'b1;
      s_q.wready  <= 1'b1;
      s_q.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rresp   = s_q.rresp;
  assign s_axi_rdata   = {24'h00_0000, s_q.rdata};
  assign pwm_pin       = s_q.pin;
  assign pwm_pin_oe    = s_q.pin_oe;
  assign irq           = s_q.irq;

endmodule

// ==== testbench/pwmcc_monitor.sv ====
// Bus and pin checks for the six-channel PWM control block.
`timescale 1ns/1ps
module pwmcc_monitor import pwmcc_pkg::*; (
  // Clock and reset
  input wire logic              clk,
  input wire logic              resetn,
  // Register bus
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  // Pins and interrupt
  input wire logic [NCH-1:0]    pwm_pin,
  input wire logic [NCH-1:0]    pwm_pin_oe,
  input wire logic              irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_pin_needs_oe: assert property ((pwm_pin & ~pwm_pin_oe) == '0)
    else $error("pin high while not driven");
  a_oe_after_reset: assert property ($rose(resetn) |-> pwm_pin_oe == '0)
    else $error("pin driven right after reset");
  a_read_turn: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_write_turn: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid)
    else $error("write answer late");
  a_no_read_while: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during read answer");
  a_no_write_while: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  a_misaligned_err: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == RESP_ERR
    && s_axi_rdata == '0) else $error("misaligned read not refused");
  c_irq: cover property ($rose(irq));
  c_write: cover property (s_axi_bvalid);
  c_pin: cover property ($rose(pwm_pin[5]));
endmodule
bind pwmcc_top pwmcc_monitor pwmcc_monitor_inst (.clk(clk), .resetn(resetn),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .pwm_pin(pwm_pin), .pwm_pin_oe(pwm_pin_oe), .irq(irq));

// ==== testbench/test_pwmcc_top.sv ====
// Self-checking bench for the six-channel PWM control block.
`timescale 1ns/1ps
module test_pwmcc_top import pwmcc_pkg::*; ();
  typedef struct packed {
    logic [7:0]           cks;
    logic [7:0]           psc;
    logic [NCH-1:0][3:0]  rise;
  } pwmcc_row_s;
  logic              clk = 0, resetn = 0, rc_tick = 0, rc2_tick = 0;
  logic [1:0]        tick_cnt = '0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hf;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
  logic              s_axi_arvalid = 0, s_axi_rready = 0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arready, s_axi_rvalid, irq;
  logic [NCH-1:0]    pwm_pin, pwm_pin_oe, last_pin;
  int                failures = 0, total_checks = 0;
  int                highs [NCH], rises [NCH];
  logic [11:0] dadr [NCH] = '{12'h2c0, 12'h2c4, 12'h2c8, 12'h26c, 12'h270,
                              12'h274};
  logic [7:0]  duty [NCH] = '{8'h10, 8'h20, 8'h40, 8'h80, 8'hc0, 8'h30};
  // Rises per 1024 cycles follow the tick rate; high time does not.
  pwmcc_row_s  rows [5] = '{'{8'h00, 8'h00, 24'h44_4444},
    '{8'h76, 8'h00, 24'h11_1241}, '{8'h2b, 8'h00, 24'h44_4112},
    '{8'h00, 8'h01, 24'h22_2444}, '{8'h00, 8'h02, 24'h11_1444}};

  pwmcc_top pwmcc_top_inst (
    .clk           (clk),
    .resetn        (resetn),
    .rc_tick       (rc_tick),
    .rc2_tick      (rc2_tick),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .pwm_pin       (pwm_pin),
    .pwm_pin_oe    (pwm_pin_oe),
    .irq           (irq)
  );

  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    rc_tick  <= tick_cnt == 2'h3;
    rc2_tick <= tick_cnt[0];
  end

  task automatic complete_run();
    if (failures == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er = RESP_OK);
    logic       aw_hit;
    logic       w_hit;
    logic       b_hit;
    logic [1:0] resp;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= 32'(d);
    s_axi_awvalid <= '1;
    s_axi_wvalid  <= '1;
    do begin
      // Ready is read where it has settled, before the edge that uses it.
      @(negedge clk);
      aw_hit = s_axi_awvalid && s_axi_awready === 1'b1;
      w_hit  = s_axi_wvalid && s_axi_wready === 1'b1;
      b_hit  = s_axi_bvalid === 1'b1;
      resp   = s_axi_bresp;
      @(posedge clk);
      if (aw_hit) s_axi_awvalid <= '0;
      if (w_hit) s_axi_wvalid <= '0;
    end while (!b_hit);
    chk("bresp", 32'(er), 32'(resp));
  endtask

  task automatic rd(input string n, input logic [11:0] a,
                    input logic [31:0] e, input logic [1:0] er);
    logic        hit;
    logic [31:0] data;
    logic [1:0]  resp;
    s_axi_araddr  <= a;
    s_axi_arvalid <= '1;
    do begin
      @(negedge clk);
      hit = s_axi_arready === 1'b1;
      @(posedge clk);
    end while (!hit);
    s_axi_arvalid <= '0;
    // Late ready keeps the answer standing for one cycle.
    @(posedge clk);
    s_axi_rready <= '1;
    do begin
      @(negedge clk);
      hit  = s_axi_rvalid === 1'b1;
      data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
    end while (!hit);
    s_axi_rready <= '0;
    chk(n, e, data);
    chk("rresp", 32'(er), 32'(resp));
  endtask

  // Outputs are read a little after the edge that launches them.
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic meas();
    #1;
    last_pin = pwm_pin;
    highs = '{default: 0};
    rises = '{default: 0};
    repeat (1024) begin
      @(posedge clk);
      #1;
      for (int i = 0; i < NCH; i++) begin
        highs[i] += int'(pwm_pin[i] === 1'b1);
        rises[i] += int'(pwm_pin[i] === 1'b1 && last_pin[i] === 1'b0);
      end
      last_pin = pwm_pin;
    end
  endtask

  initial begin
    repeat (3) @(posedge clk);
    resetn <= '1;
    @(posedge clk);
    rd("oe", 12'h278, 32'(RST_OE), RESP_OK);
    rd("clr", 12'h27c, 32'(RST_CLR), RESP_OK);
    rd("cks", 12'h284, 32'(RST_CKS), RESP_OK);
    rd("skew", 12'h279, 32'h0, RESP_ERR);
    rd("none", 12'h000, 32'h0, RESP_ERR);
    wr(12'h278, 8'hff);
    rd("oe", 12'h278, 32'h3f, RESP_OK);
    wr(12'h279, 8'h00, RESP_ERR);
    rd("oe", 12'h278, 32'h3f, RESP_OK);
    for (int i = 0; i < NCH; i++) begin
      wr(dadr[i], duty[i]);
    end
    wr(12'h27c, 8'hff);
    rd("clr", 12'h27c, 32'hbf, RESP_OK);
    wr(12'h284, 8'hff);
    rd("cks", 12'h284, 32'h7f, RESP_OK);
    meas();
    for (int i = 0; i < NCH; i++) begin
      chk("held", 32'h0, highs[i]);
    end
    chk("pin_oe", 32'h3f, 32'(pwm_pin_oe));
    wr(12'h27c, 8'h00);
    foreach (rows[r]) begin
      wr(12'h284, rows[r].cks);
      wr(12'h2d4, rows[r].psc);
      repeat (4) @(posedge clk);
      meas();
      for (int i = 0; i < NCH; i++) begin
        chk("highs", 4 * duty[i], highs[i]);
        chk("rises", 32'(rows[r].rise[i]), rises[i]);
      end
    end
    chk("irq", 32'h0, 32'(irq));
    wr(12'h2cc, 8'h83);
    settle(2);
    chk("irq", 32'h1, 32'(irq));
    wr(12'h27c, 8'h3f);
    wr(12'h2d0, 8'h07);
    rd("sts", 12'h2d0, 32'h0, RESP_OK);
    settle(0);
    chk("irq", 32'h0, 32'(irq));
    wr(12'h2cc, 8'h80);
    wr(12'h27c, 8'hbb);
    settle(300);
    chk("irq", 32'h1, 32'(irq));
    rd("sts", 12'h2d0, 32'h4, RESP_OK);
    wr(12'h2cc, 8'h00);
    settle(2);
    chk("irq", 32'h0, 32'(irq));
    wr(12'h2cc, 8'h80);
    wr(12'h27c, 8'h3b);
    settle(2);
    chk("irq", 32'h0, 32'(irq));
    wr(12'h278, 8'h00);
    settle(2);
    chk("pin_oe", 32'h0, 32'(pwm_pin_oe));
    chk("pin", 32'h0, 32'(pwm_pin));
    resetn <= '0;
    repeat (3) @(posedge clk);
    resetn <= '1;
    @(posedge clk);
    rd("cks", 12'h284, 32'(RST_CKS), RESP_OK);
    complete_run();
  end

  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    complete_run();
  end
endmodule
